// ===== include/hbpm_defines.svh
`ifndef HBPM_DEFINES_SVH
`define HBPM_DEFINES_SVH
// Strap codes on the three lower straps, one per bus family plus one reserved code.
`define HBPM_STRAP_READY 3'h0
`define HBPM_STRAP_WAIT 3'h1
`define HBPM_STRAP_RSVD 3'h2
`define HBPM_STRAP_SEPSTB 3'h3
`define HBPM_STRAP_SIZED 3'h4
`define HBPM_STRAP_GEN1 3'h5
`define HBPM_STRAP_GEN2 3'h6
// Field positions inside the strap word.
`define HBPM_STRAP_ENDIAN 3
`define HBPM_STRAP_FAM_HI 2
// Transfer size code for a single byte.
`define HBPM_SIZE_BYTE 2'h1
// Byte enable patterns.
`define HBPM_BE_NONE 2'h0
`define HBPM_BE_LO 2'h1
`define HBPM_BE_HI 2'h2
`define HBPM_BE_BOTH 2'h3
`endif

// ===== include/hbpm_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
// Raw host pins in, one normalised bus cycle out.
interface hbpm_pin_if;
   logic cs_n;
   logic bs_n;
   logic we0_n;
   logic we1_n;
   logic rd_n;
   logic dir;
   logic a0;
   hbpm_pkg::hbpm_mode_t mode;
   logic mode_ok;
   logic cyc_active;
   logic cyc_write;
   logic [1:0] cyc_be;
   logic cyc_a0;
   logic cs_seen;
   modport dec (input cs_n, bs_n, we0_n, we1_n, rd_n, dir, a0, mode, mode_ok,
      output cyc_active, cyc_write, cyc_be, cyc_a0, cs_seen);
   modport top (output cs_n, bs_n, we0_n, we1_n, rd_n, dir, a0, mode, mode_ok,
      input cyc_active, cyc_write, cyc_be, cyc_a0, cs_seen);
endinterface : hbpm_pin_if
`default_nettype wire

// ===== include/hbpm_pkg.sv
package hbpm_pkg;
   // Host bus families selectable by the straps.
   typedef enum logic [2:0] {
      HBPM_M_WAIT,
      HBPM_M_READY,
      HBPM_M_SEPSTB,
      HBPM_M_SIZED,
      HBPM_M_GEN1,
      HBPM_M_GEN2,
      HBPM_M_NONE
   } hbpm_mode_t;
   // Bus-clock side cycle states.
   typedef enum logic [1:0] {
      L_IDLE,
      L_REQ,
      L_DONE
   } hbpm_lstate_t;
endpackage : hbpm_pkg

// ===== src/hbpm_pin_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "hbpm_defines.svh"
module hbpm_pin_decode (
   input wire logic bus_clk, // Host bus clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   hbpm_pin_if.dec pins // Pins in, decoded cycle out.
);
   logic cs_p, bs_p, we0_p, we1_p, rd_p, dir_p, a0_p;
   logic act_c, wr_c, a0_c;
   logic [1:0] be_c;
   logic [1:0] size_c;

   ////////////////////////////////////////////////////////////////////////////
   // Pins are registered once on the host clock; the host drives them on it.
   always_ff @(posedge bus_clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_p <= 1'b0;
         bs_p <= 1'b0;
         we0_p <= 1'b0;
         we1_p <= 1'b0;
         rd_p <= 1'b0;
         dir_p <= 1'b1;
         a0_p <= 1'b0;
      end else begin
         cs_p <= ~pins.cs_n;
         bs_p <= ~pins.bs_n;
         we0_p <= ~pins.we0_n;
         we1_p <= ~pins.we1_n;
         rd_p <= ~pins.rd_n;
         dir_p <= pins.dir;
         a0_p <= pins.a0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-family pin roles; unused pins are held by the host and not looked at.
   always_comb begin
      act_c = 1'b0;
      wr_c = 1'b0;
      be_c = `HBPM_BE_NONE;
      a0_c = a0_p;
      size_c = {~rd_p, ~we0_p};
      case (pins.mode)
         hbpm_pkg::HBPM_M_WAIT, hbpm_pkg::HBPM_M_READY: begin
            act_c = we0_p | we1_p | rd_p;
            wr_c = ~dir_p;
            be_c = wr_c ? {we1_p, we0_p} : `HBPM_BE_BOTH;
         end
         hbpm_pkg::HBPM_M_SEPSTB: begin
            act_c = bs_p & (we1_p | ~a0_p);
            wr_c = ~dir_p;
            be_c = {we1_p, ~a0_p};
            a0_c = 1'b0;
         end
         hbpm_pkg::HBPM_M_SIZED: begin
            act_c = bs_p & we1_p;
            wr_c = ~dir_p;
            if (size_c == `HBPM_SIZE_BYTE) begin
               be_c = a0_p ? `HBPM_BE_LO : `HBPM_BE_HI;
            end else begin
               be_c = `HBPM_BE_BOTH;
            end
         end
         hbpm_pkg::HBPM_M_GEN1: begin
            act_c = we0_p | we1_p | rd_p | ~dir_p;
            wr_c = we0_p | we1_p;
            be_c = wr_c ? {we1_p, we0_p} : {~dir_p, rd_p};
         end
         hbpm_pkg::HBPM_M_GEN2: begin
            act_c = we0_p | rd_p;
            wr_c = we0_p;
            be_c = {we1_p, ~a0_p};
         end
         default: begin
            act_c = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoded cycle is registered; chip select gates every access.
   always_ff @(posedge bus_clk or negedge rst_n) begin
      if (!rst_n) begin
         pins.cyc_active <= 1'b0;
         pins.cyc_write <= 1'b0;
         pins.cyc_be <= `HBPM_BE_NONE;
         pins.cyc_a0 <= 1'b0;
         pins.cs_seen <= 1'b0;
      end else begin
         pins.cyc_active <= act_c & cs_p & pins.mode_ok;
         pins.cyc_write <= wr_c;
         pins.cyc_be <= be_c;
         pins.cyc_a0 <= a0_c;
         pins.cs_seen <= cs_p & pins.mode_ok;
      end
   end

   a_sized_byte: assert property (@(posedge bus_clk) disable iff (!rst_n)
      (pins.mode == hbpm_pkg::HBPM_M_SIZED && size_c == `HBPM_SIZE_BYTE)
      |=> (pins.cyc_be != `HBPM_BE_BOTH))
      else $error("Byte-sized transfer enabled both lanes.");
   a_sep_lane_low: assert property (@(posedge bus_clk) disable iff (!rst_n)
      (pins.mode == hbpm_pkg::HBPM_M_SEPSTB && !a0_p) |=> !pins.cyc_a0 && pins.cyc_be[0])
      else $error("Lower strobe not taken from the lowest address pin.");
   a_gen1_upper_read: assert property (@(posedge bus_clk) disable iff (!rst_n)
      (pins.mode == hbpm_pkg::HBPM_M_GEN1 && !dir_p && !we0_p && !we1_p)
      |=> pins.cyc_be[1] && !pins.cyc_write)
      else $error("Direction pin not used as upper read command.");
endmodule : hbpm_pin_decode
`default_nettype wire

// ===== src/hbpm_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "hbpm_defines.svh"
// What this block does
// - Reset clears state, outputs go inactive.
// - Low write pin: lower or single write.
// - Sized mode: write/read pins are size.
// - High write pin role per bus family.
// - Low read pin role per bus family.
// - Direction pin: read/write or upper read.
// - Start pin: bus start or address strobe.
// - Hold-off output role per family, off at reset.
// - Accesses only taken with chip select.
// - Host side timed by host bus clock.
// - Straps at reset pick family, endianness.
// - Lowest address pin: lower strobe or bit.
module hbpm_top (
   input wire logic SYS_CLK, // Core clock.
   input wire logic RESETN, // Asynchronous reset, active low.
   input wire logic CLK_EN, // Core clock enable.
   input wire logic BUS_CLK, // Host bus clock.
   input wire logic CHIP_SEL_N, // Chip select, active low.
   input wire logic BUS_CYCLE_START_N, // Bus start or address strobe.
   input wire logic LOW_BYTE_WRITE_STROBE_N, // Lower write or size bit 0.
   input wire logic HIGH_BYTE_WRITE_STROBE_N, // Upper write or data strobe.
   input wire logic LOW_BYTE_READ_N, // Read command or size bit 1.
   input wire logic DIRECTION, // Read high, write low; upper read when low in HBPM_M_GEN1.
   input wire logic ADDRESS_LOW_BIT, // Address bit 0 or lower strobe.
   input wire logic [3:0] BUS_MODE_STRAPS, // Configuration straps.
   output logic HOLD_OFF_O, // Hold-off output level.
   output logic HOLD_OFF_OE, // Hold-off output enable.
   output logic CORE_REQ_STB, // One-cycle access request to core.
   output logic CORE_REQ_WRITE, // Request is a write.
   output logic [1:0] CORE_REQ_BE, // Byte lanes of the request.
   output logic CORE_REQ_A0, // Address bit 0 of the request.
   input wire logic CORE_ACK, // Core finished the request.
   output logic [2:0] CORE_MODE, // Selected bus family.
   output logic CORE_BIG_ENDIAN // Byte order strap.
);
   hbpm_pin_if pins ();

   logic [3:0] strap_s1_r, strap_s2_r;
   logic [1:0] fill_r;
   logic cap_done_r;
   hbpm_pkg::hbpm_mode_t mode_r, mode_nxt;
   logic big_r;
   logic [2:0] bmode_s1_r, bmode_s2_r;
   logic bok_s1_r, bok_s2_r;
   hbpm_pkg::hbpm_lstate_t state_r, state_nxt;
   logic req_tgl_r;
   logic lat_write_r, lat_a0_r;
   logic [1:0] lat_be_r;
   logic ack_s1_r, ack_s2_r, ack_s3_r;
   logic ack_edge;
   logic wait_type;
   logic hold_o_r, hold_oe_r;
   logic req_s1_r, req_s2_r, req_s3_r;
   logic req_edge;
   logic pend_r;
   logic ack_tgl_r;
   logic stb_r, wr_r, a0_r;
   logic [1:0] be_r;

   ////////////////////////////////////////////////////////////////////////////
   // Straps are pins, so they pass two flops before anything reads them.
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         strap_s1_r <= 4'h0;
         strap_s2_r <= 4'h0;
         fill_r <= 2'h0;
      end else if (CLK_EN) begin
         strap_s1_r <= BUS_MODE_STRAPS;
         strap_s2_r <= strap_s1_r;
         fill_r <= {fill_r[0], 1'b1}; // Marks the synchroniser as full.
      end
   end

   // Strap family code mapped onto the bus families.
   always_comb begin
      case (strap_s2_r[`HBPM_STRAP_FAM_HI:0])
         `HBPM_STRAP_WAIT: mode_nxt = hbpm_pkg::HBPM_M_WAIT;
         `HBPM_STRAP_READY: mode_nxt = hbpm_pkg::HBPM_M_READY;
         `HBPM_STRAP_SEPSTB: mode_nxt = hbpm_pkg::HBPM_M_SEPSTB;
         `HBPM_STRAP_SIZED: mode_nxt = hbpm_pkg::HBPM_M_SIZED;
         `HBPM_STRAP_GEN1: mode_nxt = hbpm_pkg::HBPM_M_GEN1;
         `HBPM_STRAP_GEN2: mode_nxt = hbpm_pkg::HBPM_M_GEN2;
         default: mode_nxt = hbpm_pkg::HBPM_M_NONE;
      endcase
   end

   // Family and byte order are caught once after reset release and then held;
   // waiting for the synchroniser to fill keeps reset-time values out.
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cap_done_r <= 1'b0;
         mode_r <= hbpm_pkg::HBPM_M_NONE;
         big_r <= 1'b0;
      end else if (CLK_EN && fill_r[1] && !cap_done_r) begin
         cap_done_r <= 1'b1;
         mode_r <= mode_nxt;
         big_r <= strap_s2_r[`HBPM_STRAP_ENDIAN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode is static once caught, so bitwise two-flop crossing is safe; the
   // valid flag is crossed too and gates use until the value has settled.
   always_ff @(posedge BUS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         bmode_s1_r <= 3'h0;
         bmode_s2_r <= 3'h0;
         bok_s1_r <= 1'b0;
         bok_s2_r <= 1'b0;
      end else begin
         bmode_s1_r <= mode_r;
         bmode_s2_r <= bmode_s1_r;
         bok_s1_r <= cap_done_r;
         bok_s2_r <= bok_s1_r;
      end
   end

   assign pins.cs_n = CHIP_SEL_N;
   assign pins.bs_n = BUS_CYCLE_START_N;
   assign pins.we0_n = LOW_BYTE_WRITE_STROBE_N;
   assign pins.we1_n = HIGH_BYTE_WRITE_STROBE_N;
   assign pins.rd_n = LOW_BYTE_READ_N;
   assign pins.dir = DIRECTION;
   assign pins.a0 = ADDRESS_LOW_BIT;
   assign pins.mode = hbpm_pkg::hbpm_mode_t'(bmode_s2_r);
   assign pins.mode_ok = bok_s2_r;

   // Pin roles per family live in the decoder.
   hbpm_pin_decode u_dec (
      .bus_clk(BUS_CLK),
      .rst_n(RESETN),
      .pins(pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Acknowledge toggle from the core crosses into the bus clock.
   always_ff @(posedge BUS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         ack_s3_r <= 1'b0;
      end else begin
         ack_s1_r <= ack_tgl_r;
         ack_s2_r <= ack_s1_r;
         ack_s3_r <= ack_s2_r;
      end
   end
   assign ack_edge = ack_s2_r ^ ack_s3_r;

   // Bus cycle sequencing on the host clock.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hbpm_pkg::L_IDLE: begin
            if (pins.cyc_active) begin
               state_nxt = hbpm_pkg::L_REQ;
            end
         end
         hbpm_pkg::L_REQ: begin
            if (ack_edge) begin
               state_nxt = hbpm_pkg::L_DONE;
            end
         end
         hbpm_pkg::L_DONE: begin
            if (!pins.cyc_active) begin
               state_nxt = hbpm_pkg::L_IDLE;
            end
         end
         default: state_nxt = hbpm_pkg::L_IDLE;
      endcase
   end

   always_ff @(posedge BUS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r <= hbpm_pkg::L_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Cycle fields are latched as the request leaves and stay put until the
   // core answers, which is what makes the toggle crossing safe for them.
   always_ff @(posedge BUS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         req_tgl_r <= 1'b0;
         lat_write_r <= 1'b0;
         lat_be_r <= `HBPM_BE_NONE;
         lat_a0_r <= 1'b0;
      end else if (state_r == hbpm_pkg::L_IDLE && pins.cyc_active) begin
         req_tgl_r <= ~req_tgl_r;
         lat_write_r <= pins.cyc_write;
         lat_be_r <= pins.cyc_be;
         lat_a0_r <= pins.cyc_a0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wait-style families pull low while busy; acknowledge-style ones pull low
   // once done. The line is released without chip select so it can be shared.
   always_comb begin
      case (hbpm_pkg::hbpm_mode_t'(bmode_s2_r))
         hbpm_pkg::HBPM_M_SEPSTB, hbpm_pkg::HBPM_M_SIZED, hbpm_pkg::HBPM_M_READY: begin
            wait_type = 1'b0;
         end
         default: wait_type = 1'b1;
      endcase
   end

   always_ff @(posedge BUS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         hold_o_r <= 1'b1;
         hold_oe_r <= 1'b0;
      end else begin
         hold_oe_r <= pins.cs_seen;
         if (wait_type) begin
            hold_o_r <= (state_nxt != hbpm_pkg::L_REQ);
         end else begin
            hold_o_r <= (state_nxt != hbpm_pkg::L_DONE);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request toggle crosses into the core clock; third flop finds the edge.
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
      end else if (CLK_EN) begin
         req_s1_r <= req_tgl_r;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
      end
   end
   assign req_edge = req_s2_r ^ req_s3_r;

   // One-cycle strobe to the core with the latched cycle fields.
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         stb_r <= 1'b0;
         wr_r <= 1'b0;
         be_r <= `HBPM_BE_NONE;
         a0_r <= 1'b0;
      end else if (CLK_EN) begin
         stb_r <= req_edge;
         if (req_edge) begin
            wr_r <= lat_write_r;
            be_r <= lat_be_r;
            a0_r <= lat_a0_r;
         end
      end
   end

   // Core acknowledge is only honoured while a request is pending; a stray
   // acknowledge cannot release a host cycle that was never issued.
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pend_r <= 1'b0;
         ack_tgl_r <= 1'b0;
      end else if (CLK_EN) begin
         if (req_edge) begin
            pend_r <= 1'b1;
         end else if (pend_r && CORE_ACK) begin
            pend_r <= 1'b0;
            ack_tgl_r <= ~ack_tgl_r;
         end
      end
   end

   assign HOLD_OFF_O = hold_o_r;
   assign HOLD_OFF_OE = hold_oe_r;
   assign CORE_REQ_STB = stb_r;
   assign CORE_REQ_WRITE = wr_r;
   assign CORE_REQ_BE = be_r;
   assign CORE_REQ_A0 = a0_r;
   assign CORE_MODE = mode_r;
   assign CORE_BIG_ENDIAN = big_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the host and core clock sides.
   sequence s_enter_req;
      state_r == hbpm_pkg::L_IDLE ##1 state_r == hbpm_pkg::L_REQ;
   endsequence
   sequence s_enter_done;
      state_r == hbpm_pkg::L_REQ ##1 state_r == hbpm_pkg::L_DONE;
   endsequence

   a_req_toggles: assert property (@(posedge BUS_CLK) disable iff (!RESETN)
      s_enter_req |-> (req_tgl_r != $past(req_tgl_r)) && $past(pins.cyc_active))
      else $error("Bus cycle entered without chip-selected request.");
   a_wait_busy: assert property (@(posedge BUS_CLK) disable iff (!RESETN)
      (state_r == hbpm_pkg::L_REQ && wait_type) |-> !hold_o_r)
      else $error("Wait not asserted while cycle is pending.");
   a_ack_done: assert property (@(posedge BUS_CLK) disable iff (!RESETN)
      s_enter_done |-> (!wait_type ? !hold_o_r : hold_o_r))
      else $error("Completion level wrong on hold-off output.");
   a_holdoff_cs: assert property (@(posedge BUS_CLK) disable iff (!RESETN)
      hold_oe_r |-> $past(pins.cs_seen))
      else $error("Hold-off driven without chip select.");
   a_reset_quiet: assert property (@(posedge SYS_CLK)
      !RESETN |-> !CORE_REQ_STB && !hold_oe_r && !pend_r)
      else $error("Output active during reset.");
   a_strobe_single: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (CORE_REQ_STB && CLK_EN) |=> !CORE_REQ_STB && pend_r)
      else $error("Request strobe longer than one cycle.");
   a_mode_held: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      cap_done_r |=> $stable(mode_r) && $stable(big_r))
      else $error("Bus family changed after capture.");
endmodule : hbpm_top
`default_nettype wire

// ===== verif/hbpm_host_model.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host processor model: runs one bus cycle at a time on the host pins.
module hbpm_host_model (
   input wire logic bus_clk, // Host bus clock.
   input wire logic hold_off_o, // Hold-off level from the device.
   input wire logic hold_off_oe, // Hold-off enable from the device.
   output var logic cs_n, // Chip select, active low.
   output var logic [5:0] pins // Start, low write, high write, read, direction, bit 0.
);
   wire logic hold;

   // The hold-off line carries a pull-up, so a released line reads high.
   assign hold = hold_off_oe ? hold_off_o : 1'b1;

   // Unused pins rest at their fixed levels from time zero.
   initial begin
      cs_n = 1'b1;
      pins = 6'h3f;
   end

   // Style 0 waits for a wait pulse, style 1 for an acknowledge, style 2 for nothing.
   // Every wait is bounded so that a silent device cannot hang the host.
   task automatic cycle(input logic cs_lo, input logic [5:0] act, input logic [5:0] idle,
                        input logic [1:0] st, output logic ok);
      int n;
      @(posedge bus_clk);
      cs_n <= ~cs_lo;
      pins <= act;
      ok = 1'b1;
      n = 0;
      if (st == 2'h0) begin
         while (hold !== 1'b0 && n < 20) begin
            @(posedge bus_clk);
            n++;
         end
         ok = (n < 20);
         n = 0;
         while (hold !== 1'b1 && n < 60) begin
            @(posedge bus_clk);
            n++;
         end
      end else if (st == 2'h1) begin
         while (hold !== 1'b0 && n < 60) begin
            @(posedge bus_clk);
            n++;
         end
      end else begin
         repeat (8) @(posedge bus_clk);
      end
      ok = ok && (n < 60);
      // Release strobes and select together, then rest before the next cycle.
      pins <= idle;
      cs_n <= 1'b1;
      repeat (4) @(posedge bus_clk);
   endtask : cycle
endmodule : hbpm_host_model
`default_nettype wire

// ===== verif/hbpm_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module hbpm_top_tb;
   logic SYS_CLK = 1'b0;
   logic BUS_CLK = 1'b0;
   logic RESETN = 1'b1;
   logic CORE_ACK = 1'b0;
   logic [3:0] BUS_MODE_STRAPS = 4'h0;
   logic HOLD_OFF_O, HOLD_OFF_OE, CORE_REQ_STB, CORE_REQ_WRITE, CORE_REQ_A0;
   logic CORE_BIG_ENDIAN, cs_n, oe_seen, ok;
   logic [1:0] CORE_REQ_BE, st;
   logic [2:0] CORE_MODE, m;
   logic [5:0] pins, act, idle;
   logic [3:0] ex, ack_dly = 4'h0;
   logic [31:0] rnd = 32'h00012e53;
   logic [3:0] exp_q[$];
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   logic [2:0] mtab [8] = '{hbpm_pkg::HBPM_M_READY, hbpm_pkg::HBPM_M_WAIT,
      hbpm_pkg::HBPM_M_NONE, hbpm_pkg::HBPM_M_SEPSTB, hbpm_pkg::HBPM_M_SIZED,
      hbpm_pkg::HBPM_M_GEN1, hbpm_pkg::HBPM_M_GEN2, hbpm_pkg::HBPM_M_NONE};

   // The two clocks share no rising edges, so the crossing is exercised in earnest.
   always #25 SYS_CLK = ~SYS_CLK;
   always #62.5 BUS_CLK = ~BUS_CLK;

   hbpm_top dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(1'b1), .BUS_CLK(BUS_CLK),
      .CHIP_SEL_N(cs_n), .BUS_CYCLE_START_N(pins[5]), .LOW_BYTE_WRITE_STROBE_N(pins[4]),
      .HIGH_BYTE_WRITE_STROBE_N(pins[3]), .LOW_BYTE_READ_N(pins[2]), .DIRECTION(pins[1]),
      .ADDRESS_LOW_BIT(pins[0]), .BUS_MODE_STRAPS(BUS_MODE_STRAPS), .HOLD_OFF_O(HOLD_OFF_O),
      .HOLD_OFF_OE(HOLD_OFF_OE), .CORE_REQ_STB(CORE_REQ_STB), .CORE_REQ_WRITE(CORE_REQ_WRITE),
      .CORE_REQ_BE(CORE_REQ_BE), .CORE_REQ_A0(CORE_REQ_A0), .CORE_ACK(CORE_ACK),
      .CORE_MODE(CORE_MODE), .CORE_BIG_ENDIAN(CORE_BIG_ENDIAN));

   hbpm_host_model host (.bus_clk(BUS_CLK), .hold_off_o(HOLD_OFF_O),
      .hold_off_oe(HOLD_OFF_OE), .cs_n(cs_n), .pins(pins));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return v[0] ? ((v >> 1) ^ 32'h80200003) : (v >> 1);
   endfunction : lfsr

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic final_report();
      if (n_fail == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report

   // Pin patterns as {start, low write, high write, read, direction, bit 0}.
   // Expected request is {write, byte lanes, bit 0}.
   task automatic build(input logic w, output logic [5:0] a, output logic [5:0] i,
                        output logic [1:0] s, output logic [3:0] e);
      logic [1:0] l;
      logic [1:0] sz;
      logic r;
      rnd = lfsr(rnd);
      l = (rnd[1:0] == 2'h0) ? 2'h3 : rnd[1:0];
      r = rnd[2];
      sz = rnd[3] ? 2'h1 : 2'h2;
      i = 6'h3f;
      s = 2'h1;
      a = w ? {1'b0, ~l[0], ~l[1], 2'b10, r} : {5'b01101, r};
      e = w ? {1'b1, l, r} : {1'b0, 2'h3, r};
      case (m)
         hbpm_pkg::HBPM_M_WAIT: s = 2'h0;
         hbpm_pkg::HBPM_M_READY: s = 2'h1;
         hbpm_pkg::HBPM_M_SEPSTB: begin
            a = {1'b0, 1'b1, ~l[1], 1'b1, ~w, ~l[0]};
            e = {w, l, 1'b0};
         end
         hbpm_pkg::HBPM_M_SIZED: begin
            a = {1'b0, sz[0], 1'b0, sz[1], ~w, r};
            e = {w, (sz == 2'h1) ? (r ? 2'h1 : 2'h2) : 2'h3, r};
         end
         hbpm_pkg::HBPM_M_GEN1: begin
            i = 6'h1f;
            a = w ? {1'b0, ~l[0], ~l[1], 2'b11, r} : {3'b011, ~l[0], ~l[1], r};
            e = {w, l, r};
            s = 2'h0;
         end
         hbpm_pkg::HBPM_M_GEN2: begin
            a = {1'b1, ~w, ~l[1], w, 1'b1, ~l[0]};
            e = {w, l, ~l[0]};
            s = 2'h0;
         end
         default: s = 2'h2;
      endcase
   endtask : build

   ////////////////////////////////////////////////////////////////////////////
   // Core stand-in: acknowledges each request after a short random delay.
   always @(posedge SYS_CLK) begin
      if (CORE_REQ_STB === 1'b1) begin
         ack_dly <= {2'h0, rnd[5:4]} + 4'h1;
      end else if (ack_dly != 4'h0) begin
         ack_dly <= ack_dly - 4'h1;
      end
      CORE_ACK <= (ack_dly == 4'h1);
   end

   // Watcher: every request pulse consumes the oldest expected note.
   always @(posedge SYS_CLK) begin
      if (HOLD_OFF_OE !== 1'b0) begin
         oe_seen <= 1'b1;
      end
      if (CORE_REQ_STB === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("req_unexpected", 8'h0, 8'h1);
         end else begin
            chk("req", {4'h0, exp_q.pop_front()},
                {4'h0, CORE_REQ_WRITE, CORE_REQ_BE, CORE_REQ_A0});
         end
      end
   end

   // A hang is cut short well beyond the length of the planned traffic.
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: every strap code, a refused cycle, then writes and reads.
   initial begin
      for (int s = 0; s < 8; s++) begin
         rnd = lfsr(rnd);
         @(posedge SYS_CLK);
         RESETN <= 1'b0;
         BUS_MODE_STRAPS <= {rnd[7], 3'(s)};
         repeat (10) @(posedge SYS_CLK);
         chk("rst_oe", 8'h0, {7'h0, HOLD_OFF_OE});
         chk("rst_out", 8'h4, {5'h0, HOLD_OFF_O, CORE_REQ_STB, CORE_REQ_WRITE});
         chk("rst_mode", 8'(hbpm_pkg::HBPM_M_NONE), {5'h0, CORE_MODE});
         RESETN <= 1'b1;
         repeat (16) @(posedge SYS_CLK);
         m = mtab[s];
         chk("mode", {5'h0, m}, {5'h0, CORE_MODE});
         chk("endian", {7'h0, BUS_MODE_STRAPS[3]}, {7'h0, CORE_BIG_ENDIAN});
         build(1'b1, act, idle, st, ex);
         oe_seen = 1'b0;
         host.cycle(1'b0, act, idle, 2'h2, ok);
         chk("refused_oe", 8'h0, {7'h0, oe_seen});
         for (int k = 0; k < 6; k++) begin
            build(k[0], act, idle, st, ex);
            oe_seen = 1'b0;
            if (st != 2'h2) begin
               exp_q.push_back(ex);
            end
            host.cycle(1'b1, act, idle, st, ok);
            chk("host_done", 8'h1, {7'h0, ok});
            chk("queue_left", 8'h0, 8'(exp_q.size()));
            chk("oe_idle", 8'h0, {7'h0, HOLD_OFF_OE});
            // With no bus family the line is still driven, idle, under chip select.
            if (st == 2'h2) begin
               chk("none_oe", 8'h1, {7'h0, oe_seen});
            end
         end
      end
      final_report();
   end
endmodule : hbpm_top_tb
`default_nettype wire
